// >>> dv/bcc_checker.sv
/*
  Port checker of the commutation core: hold-off, overrides, gate shapes, brake debounce.
  Assumes binding into bcc_top; one clock, aclk, synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module bcc_checker #(
  parameter logic [15:0] OSC_DIV_DEFAULT = 16'h2710
)
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       stop_request_n,
  input wire logic [7:0] speed_level,
  input wire logic       supply_low,
  input wire logic       high_side_gate_a,
  input wire logic       high_side_gate_b,
  input wire logic       high_side_gate_c,
  input wire logic       low_side_gate_a,
  input wire logic       low_side_gate_b,
  input wire logic       low_side_gate_c
);
  localparam int HOLD = 3 * 256 * OSC_DIV_DEFAULT;
  localparam int FAST = 32 * OSC_DIV_DEFAULT;
  logic [2:0]  hi;
  logic [2:0]  lo;
  logic        off;
  logic        brake;
  logic        lvl_low;
  logic [31:0] up_ff;
  logic [31:0] low_ff;
  assign hi      = {high_side_gate_a, high_side_gate_b, high_side_gate_c};
  assign lo      = {low_side_gate_a, low_side_gate_b, low_side_gate_c};
  assign off     = ({hi, lo} == 6'h00);
  assign brake   = ({hi, lo} == 6'h07);
  assign lvl_low = (speed_level < 8'h28);
  // up_ff: cycles since reset release; low_ff: cycles stop_request_n has been low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_ff  <= 32'h0;
      low_ff <= 32'h0;
    end else begin
      up_ff  <= up_ff + 32'h1;
      low_ff <= stop_request_n ? 32'h0 : low_ff + 32'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  property p_holdoff;    up_ff < HOLD - 4 |-> off; endproperty
  property p_dis_off;    lvl_low [*2] |=> off; endproperty
  property p_on_level;   !off |-> $past(speed_level, 2) >= 8'h28; endproperty
  property p_uv_off;     supply_low |=> off; endproperty
  property p_brake_hi;   lo == 3'h7 |-> hi == 3'h0; endproperty
  property p_no_shoot;   (hi & lo) == 3'h0; endproperty
  property p_shape;      !off && !brake |-> $onehot(hi) && $onehot(lo); endproperty
  property p_brake_dbnc; $rose(brake) |-> low_ff >= 2 * FAST - 2; endproperty
  a_holdoff:    assert property (p_holdoff) else $error("gate on during hold-off");
  a_dis_off:    assert property (p_dis_off) else $error("gate on while disabled");
  a_on_level:   assert property (p_on_level) else $error("gate on below level");
  a_uv_off:     assert property (p_uv_off) else $error("gate on at low supply");
  a_brake_hi:   assert property (p_brake_hi) else $error("high side on in brake");
  a_no_shoot:   assert property (p_no_shoot) else $error("phase shoot-through");
  a_shape:      assert property (p_shape) else $error("bad gate pattern");
  a_brake_dbnc: assert property (p_brake_dbnc) else $error("brake too early");
  c_brake:      cover property ($rose(brake));
  c_dis_brake:  cover property (brake ##1 lvl_low);
  c_step:       cover property (!off && !brake);
endmodule

bind bcc_top bcc_checker #(.OSC_DIV_DEFAULT(OSC_DIV_DEFAULT)) u_bcc_checker (
  .aclk(aclk), .aresetn(aresetn), .stop_request_n(stop_request_n),
  .speed_level(speed_level), .supply_low(supply_low),
  .high_side_gate_a(high_side_gate_a), .high_side_gate_b(high_side_gate_b),
  .high_side_gate_c(high_side_gate_c), .low_side_gate_a(low_side_gate_a),
  .low_side_gate_b(low_side_gate_b), .low_side_gate_c(low_side_gate_c)
);

// >>> dv/bcc_hall_model.sv
/*
  Rotor sensor model: turns an electrical step 0..5 into a 60 or 120 degree sensor code.
  Assumes step is driven after clock edges and stays below 6.
*/
`timescale 1ns/1ps
module bcc_hall_model (
  input  wire logic [2:0] step,
  input  wire logic       sp60,
  output logic            sa,
  output logic            sb,
  output logic            sc
);
  localparam logic [2:0] C60 [6]  = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h3, 3'h1};
  localparam logic [2:0] C120 [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  assign {sa, sb, sc} = sp60 ? C60[step] : C120[step];
endmodule

// >>> dv/bcc_top_tb_top.sv
/*
  Self-checking bench of the commutation core: decode, selects, brake, overrides, registers.
  Assumes the oscillator divider shortened to 2 cycles so counts stay small.
*/
`timescale 1ns/1ps
module bcc_top_tb_top;
  localparam int SLOW = 256 * 2;
  localparam int FAST = 32 * 2;
  localparam logic [5:0] FWD [6] = '{6'h22, 6'h21, 6'h11, 6'h14, 6'h0C, 6'h0A};
  logic aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, sa, sb, sc, mode;
  logic dir, spc, stop_n, uv, ha, hb, hc, la, lb, lc;
  logic [7:0]  awa, ara, spd;
  logic [31:0] wd, rd;
  logic [1:0]  bresp, rresp;
  logic [2:0]  step;
  logic [5:0]  g;
  int          n_fail, samples_checked;
  assign g = {ha, hb, hc, la, lb, lc};
  bcc_top #(.OSC_DIV_DEFAULT(16'h0002)) u_bcc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .rotor_sensor_a(sa),
    .rotor_sensor_b(sb), .rotor_sensor_c(sc), .direction_select(dir),
    .sensor_spacing_select(spc), .stop_request_n(stop_n), .speed_level(spd),
    .supply_low(uv), .high_side_gate_a(ha), .high_side_gate_b(hb), .high_side_gate_c(hc),
    .low_side_gate_a(la), .low_side_gate_b(lb), .low_side_gate_c(lc));
  bcc_hall_model u_bcc_hall_model (.step(step), .sp60(mode), .sa(sa), .sb(sb), .sc(sc));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] rev(input logic [5:0] x);
    return {x[2:0], x[5:3]};
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // outputs are judged at the falling edge, well away from the updating edge
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha_, hw_, dn;
    dn = 1'b0;
    @(posedge aclk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    while (!dn) begin
      @(negedge aclk);
      ha_ = awv && awr; hw_ = wv && wr; dn = bv && br; r = bresp;
      @(posedge aclk);
      if (ha_) awv <= 1'b0;
      if (hw_) wv <= 1'b0;
      if (dn) br <= 1'b0;
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic hit, dn;
    dn = 1'b0;
    @(posedge aclk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    while (!dn) begin
      @(negedge aclk);
      hit = arv && arr; dn = rv && rr; d = rd; r = rresp;
      @(posedge aclk);
      if (hit) arv <= 1'b0;
      if (dn) rr <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_holdoff;
    wt(3 * SLOW - 8);
    cmp(32'(g), 32'h0, "gates during hold-off");
    wt(16);
    cmp(32'(g), 32'(FWD[0]), "gates after hold-off");
  endtask
  task automatic t_decode(input logic fwd);
    for (int s = 5; s >= 0; s--) begin
      @(posedge aclk);
      step <= 3'(s);
      wt(2);
      cmp(32'(g), 32'(fwd ? FWD[s] : rev(FWD[s])), "decode");
    end
  endtask
  task automatic t_dbnc(input logic d, input logic sp, input logic [5:0] pre, post);
    @(posedge aclk);
    dir <= d;
    spc <= sp;
    wt(2 * SLOW - 4);
    cmp(32'(g), 32'(pre), "select early");
    wt(SLOW + 16);
    cmp(32'(g), 32'(post), "select late");
  endtask
  task automatic t_brake;
    @(posedge aclk);
    stop_n <= 1'b0;
    wt(2 * FAST - 4);
    cmp(32'(g), 32'(FWD[0]), "brake early");
    wt(FAST + 12);
    cmp(32'(g), 32'h07, "brake pattern");
    @(posedge aclk);
    spd <= 8'h27;
    wt(3);
    cmp(32'(g), 32'h0, "disable in brake");
    @(posedge aclk);
    spd <= 8'h28;
    wt(3);
    cmp(32'(g), 32'h07, "level at threshold");
    @(posedge aclk);
    uv <= 1'b1;
    wt(2);
    cmp(32'(g), 32'h0, "low supply");
    @(posedge aclk);
    uv <= 1'b0;
    wt(2);
    cmp(32'(g), 32'h07, "supply recovered");
    @(posedge aclk);
    stop_n <= 1'b1;
    spd <= 8'hC8;
    wt(2 * FAST - 4);
    cmp(32'(g), 32'h07, "release early");
    wt(FAST + 12);
    cmp(32'(g), 32'(FWD[0]), "brake released");
  endtask
  task automatic t_axi;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h00, 32'h1, r);
    cmp(32'(r), 32'h0, "ctrl write resp");
    wt(3);
    cmp(32'(g), 32'h0, "soft off");
    axi_rd(8'h08, d, r);
    cmp(d, 32'hDD, "status");
    axi_rd(8'h0C, d, r);
    cmp(d, 32'hC8, "speed reg");
    axi_rd(8'h10, d, r);
    cmp({d[29:0], r}, 32'h2, "unmapped read");
    axi_wr(8'h10, 32'h1, r);
    cmp(32'(r), 32'h2, "unmapped write");
    axi_wr(8'h04, 32'h1, r);
    axi_rd(8'h04, d, r);
    cmp(d, 32'h2, "divider clamp");
    axi_wr(8'h00, 32'h0, r);
    wt(3);
    cmp(32'(g), 32'(FWD[0]), "soft off cleared");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; step = 3'h0; mode = 1'b1; dir = 1'b1;
    spc = 1'b1; stop_n = 1'b1; spd = 8'hC8; uv = 1'b0; n_fail = 0; samples_checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_holdoff();
    t_decode(1'b1);
    t_dbnc(1'b0, 1'b1, FWD[0], rev(FWD[0]));
    t_decode(1'b0);
    t_dbnc(1'b0, 1'b0, rev(FWD[0]), 6'h00);
    @(posedge aclk);
    mode <= 1'b0;
    t_decode(1'b0);
    t_dbnc(1'b1, 1'b0, rev(FWD[0]), FWD[0]);
    t_decode(1'b1);
    t_brake();
    t_axi();
    stop_test();
  end
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    stop_test();
  end
endmodule

// >>> hdl/bcc_debounce.sv
/*
  One input debouncer: a new level is taken after three equal samples.
  Assumes raw is synchronous to aclk; smp is a one-cycle strobe.
*/
`timescale 1ns/1ps
module bcc_debounce
  import bcc_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic smp,
  input  wire logic raw,
  output logic      level
);
  bcc_deb_st_t st_ff;
  bcc_deb_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (smp) begin
      nxt_st.s1 = raw;
      nxt_st.s2 = st_ff.s1;
      // change accepted 2 to 3 sample periods after the raw edge
      if (raw == st_ff.s1 && st_ff.s1 == st_ff.s2) begin
        nxt_st.out = raw;
      end
    end
  end

  // pulled-up pins idle high, so the filter starts high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign level = st_ff.out;
endmodule

// >>> hdl/bcc_pkg.sv
/*
  Types of the commutation core.
  Assumes bcc_regs.svh is compiled alongside.
*/
package bcc_pkg;

  typedef enum logic [1:0] {SPD_DISABLE, SPD_ZERO, SPD_PARTIAL, SPD_FULL} bcc_speed_t;

  typedef enum logic {RUN_HOLD, RUN_GO} bcc_run_t;

  typedef struct packed {
    logic [15:0] osc_cnt;
    logic [7:0]  tick_cnt;
    logic        slow;
    logic        fast;
  } bcc_tb_st_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
  } bcc_deb_st_t;

  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  awaddr;
    logic        w_ok;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        soft_off;
    logic [15:0] osc_div;
    bcc_run_t    run;
    logic [1:0]  hold_cnt;
    logic [2:0]  hi;
    logic [2:0]  lo;
    bcc_speed_t  speed;
    logic [7:0]  level;
    logic        sensor_bad;
  } bcc_top_st_t;

endpackage

// >>> hdl/bcc_regs.svh
/*
  Offsets, field positions, reset values and timing counts of the commutation core.
  Assumes a 250 MHz aclk and a nominal 25 kHz commutation oscillator.
*/
`ifndef BCC_REGS_SVH
`define BCC_REGS_SVH

// register byte offsets
`define BCC_OFS_CTRL        8'h00
`define BCC_OFS_OSC_DIV     8'h04
`define BCC_OFS_STATUS      8'h08
`define BCC_OFS_SPEED       8'h0C

// control fields and reset values
`define BCC_CTRL_SOFT_OFF   0
`define BCC_CTRL_RESET      1'h0
`define BCC_OSC_DIV_MIN     16'h0002

// status fields
`define BCC_ST_FWD          0
`define BCC_ST_SPACING_60   1
`define BCC_ST_STOP_N       2
`define BCC_ST_HOLDOFF_DONE 3
`define BCC_ST_DISABLE      4
`define BCC_ST_SUPPLY_LOW   5
`define BCC_ST_SPEED_LSB    6
`define BCC_ST_GATE_LSB     8
`define BCC_ST_SENSOR_BAD   14

// timing: clock and nominal oscillator
`define BCC_CLK_FREQ_HZ     250000000
`define BCC_OSC_FREQ_HZ     25000
`define BCC_OSC_DIV_CYCLES  (`BCC_CLK_FREQ_HZ / `BCC_OSC_FREQ_HZ)
`define BCC_SLOW_RATIO      256
`define BCC_FAST_RATIO      32
`define BCC_DEB_STAGES      2
`define BCC_HOLDOFF_MIN_US  18600
`define BCC_HOLDOFF_MAX_US  35600
`define BCC_HOLDOFF_SLOW    2'h3

// speed input levels as fractions of 256 (16, 35.7 and 64.3 percent of reference)
`define BCC_LVL_DISABLE     8'(160 * 256 / 1000)
`define BCC_LVL_ZERO        8'(357 * 256 / 1000)
`define BCC_LVL_FULL        8'(643 * 256 / 1000)

// axi responses
`define BCC_RESP_OKAY       2'h0
`define BCC_RESP_SLVERR     2'h2

`endif

// >>> hdl/bcc_tick_if.sv
/*
  Sampling strobes passed from the timebase to the debouncers.
  Assumes one clock domain, aclk.
*/
`timescale 1ns/1ps
interface bcc_tick_if;
  logic slow_smp;
  logic fast_smp;
  modport src (output slow_smp, output fast_smp);
  modport snk (input slow_smp, input fast_smp);
endinterface

// >>> hdl/bcc_timebase.sv
/*
  Oscillator period tick and the slow and fast debounce sampling strobes.
  Assumes osc_div is at least 2 and changes only rarely.
*/
`timescale 1ns/1ps
`include "bcc_regs.svh"
module bcc_timebase
  import bcc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [15:0] osc_div,
  bcc_tick_if.src          tk
);
  bcc_tb_st_t st_ff;
  bcc_tb_st_t nxt_st;
  logic       osc_tick;

  always_comb begin
    nxt_st   = st_ff;
    osc_tick = (st_ff.osc_cnt >= osc_div - 16'h0001);
    nxt_st.slow = 1'b0;
    nxt_st.fast = 1'b0;
    if (osc_tick) begin
      nxt_st.osc_cnt  = 16'h0000;
      nxt_st.tick_cnt = st_ff.tick_cnt + 8'h01;
      // both strobes are enables from the one oscillator tick
      nxt_st.fast = (st_ff.tick_cnt[4:0] == 5'(`BCC_FAST_RATIO - 1));
      nxt_st.slow = (st_ff.tick_cnt == 8'(`BCC_SLOW_RATIO - 1));
    end else begin
      nxt_st.osc_cnt = st_ff.osc_cnt + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tk.slow_smp = st_ff.slow;
  assign tk.fast_smp = st_ff.fast;
endmodule

// >>> hdl/bcc_top.sv
/*
  Commutation control core: sensor decode, direction and spacing select, stop
  request and disable overrides, start-up hold-off, AXI4-Lite register slave.
  Assumes all pins synchronous to aclk; speed_level is a digitised fraction of
  the reference (255 = full reference); supply_low comes from an analog comparator.
*/
// The address map and the AXI4-Lite slave port were left to the implementer.
// Summary of operation
// - spacing and direction selects are sampled every 256 oscillator periods.
// - stop request is sampled every 32 oscillator periods.
// - a debounced change is accepted after two to three sample periods.
// - all gates stay off after start-up longer than the slow debounce.
// - debounced stop request low turns all low sides on, high sides off.
// - disable turns every gate off.
// - disable wins over stop request.
// - disable during braking ends braking at once, all gates off.
// - speed input below 16 percent is disable; 35.7 and 64.3 percent only set the status speed class, not the gate duty.
// - the three sensor inputs decode into the commutation gate pattern.
// - debounced spacing select picks 60 or 120 degree decode.
// - debounced direction select reverses the commutation sequence.
// - direction high is forward, low is reverse.
// - spacing high is 60 degrees, low is 120 degrees.
// - decode follows the truth table; forward 60 degree 000 drives A high, B low.
// - supply below threshold turns every gate off until it recovers.
`timescale 1ns/1ps
`include "bcc_regs.svh"
module bcc_top
  import bcc_pkg::*;
#(
  parameter logic [15:0] OSC_DIV_DEFAULT = 16'(`BCC_OSC_DIV_CYCLES)
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rotor_sensor_a,
  input  wire logic        rotor_sensor_b,
  input  wire logic        rotor_sensor_c,
  input  wire logic        direction_select,
  input  wire logic        sensor_spacing_select,
  input  wire logic        stop_request_n,
  input  wire logic [7:0]  speed_level,
  input  wire logic        supply_low,
  output logic             high_side_gate_a,
  output logic             high_side_gate_b,
  output logic             high_side_gate_c,
  output logic             low_side_gate_a,
  output logic             low_side_gate_b,
  output logic             low_side_gate_c
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // sensor code to step 0..5 of the 60 degree sequence, 7 for an impossible code
  function automatic logic [2:0] sensor_step(input logic [2:0] code, input logic sp60);
    logic [2:0] step;
    step = 3'h7;
    if (sp60) begin
      case (code)
        3'b000:  step = 3'h0;
        3'b100:  step = 3'h1;
        3'b110:  step = 3'h2;
        3'b111:  step = 3'h3;
        3'b011:  step = 3'h4;
        3'b001:  step = 3'h5;
        default: step = 3'h7;
      endcase
    end else begin
      case (code)
        3'b101:  step = 3'h0;
        3'b100:  step = 3'h1;
        3'b110:  step = 3'h2;
        3'b010:  step = 3'h3;
        3'b011:  step = 3'h4;
        3'b001:  step = 3'h5;
        default: step = 3'h7;
      endcase
    end
    return step;
  endfunction

  // step to {high[a,b,c], low[a,b,c]} in forward rotation
  function automatic logic [5:0] step_drive(input logic [2:0] step);
    logic [5:0] d;
    case (step)
      3'h0:    d = 6'b100_010;
      3'h1:    d = 6'b100_001;
      3'h2:    d = 6'b010_001;
      3'h3:    d = 6'b010_100;
      3'h4:    d = 6'b001_100;
      3'h5:    d = 6'b001_010;
      default: d = 6'b000_000;
    endcase
    return d;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // timebase and debouncers

  bcc_top_st_t st_ff;
  bcc_top_st_t nxt_st;
  bcc_tick_if  tk ();
  logic        fwd_db;
  logic        sp60_db;
  logic        stop_n_db;

  bcc_timebase u_timebase (
    .aclk    (aclk),
    .aresetn (aresetn),
    .osc_div (st_ff.osc_div),
    .tk      (tk.src)
  );

  bcc_debounce u_deb_dir (
    .aclk    (aclk),
    .aresetn (aresetn),
    .smp     (tk.slow_smp),
    .raw     (direction_select),
    .level   (fwd_db)
  );

  bcc_debounce u_deb_spacing (
    .aclk    (aclk),
    .aresetn (aresetn),
    .smp     (tk.slow_smp),
    .raw     (sensor_spacing_select),
    .level   (sp60_db)
  );

  bcc_debounce u_deb_stop (
    .aclk    (aclk),
    .aresetn (aresetn),
    .smp     (tk.fast_smp),
    .raw     (stop_request_n),
    .level   (stop_n_db)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  logic [2:0]  step;
  logic [5:0]  drive;
  logic        dis;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [31:0] status;

  always_comb begin
    nxt_st = st_ff;

    // speed input classification against the internal divider levels
    nxt_st.level = speed_level;
    if (speed_level < `BCC_LVL_DISABLE) begin
      nxt_st.speed = SPD_DISABLE;
    end else if (speed_level <= `BCC_LVL_ZERO) begin
      nxt_st.speed = SPD_ZERO;
    end else if (speed_level >= `BCC_LVL_FULL) begin
      nxt_st.speed = SPD_FULL;
    end else begin
      nxt_st.speed = SPD_PARTIAL;
    end
    dis = (st_ff.speed == SPD_DISABLE) || st_ff.soft_off;

    // hold-off counts whole slow periods from reset, so it outlasts the slow filter
    // hold-off ends on the third slow strobe; afterwards the core stays running
    case (st_ff.run)
      RUN_HOLD: begin
        if (tk.slow_smp) begin
          nxt_st.hold_cnt = st_ff.hold_cnt + 2'h1;
          if (st_ff.hold_cnt == `BCC_HOLDOFF_SLOW - 2'h1) begin
            nxt_st.run = RUN_GO;
          end
        end
      end
      RUN_GO:  nxt_st.run = RUN_GO;
      default: nxt_st.run = RUN_HOLD;
    endcase

    // gate pattern, highest priority first
    step  = sensor_step({rotor_sensor_a, rotor_sensor_b, rotor_sensor_c}, sp60_db);
    drive = step_drive(step);
    nxt_st.sensor_bad = (step == 3'h7);
    if (supply_low || st_ff.run != RUN_GO || dis) begin
      nxt_st.hi = 3'b000;
      nxt_st.lo = 3'b000;
    end else if (!stop_n_db) begin
      // braking ignores the sensors and is always at full strength
      nxt_st.hi = 3'b000;
      nxt_st.lo = 3'b111;
    end else if (fwd_db) begin
      nxt_st.hi = drive[5:3];
      nxt_st.lo = drive[2:0];
    end else begin
      // reverse is the forward pattern with high and low sides exchanged
      nxt_st.hi = drive[2:0];
      nxt_st.lo = drive[5:3];
    end

    // axi write: address and data taken in either order, answered once both held
    if (s_axi_awvalid && !st_ff.aw_ok && !st_ff.bvalid) begin
      nxt_st.aw_ok  = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_ff.w_ok && !st_ff.bvalid) begin
      nxt_st.w_ok  = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    wr_go  = st_ff.aw_ok && st_ff.w_ok && !st_ff.bvalid;
    wr_hit = 1'b0;
    if (wr_go) begin
      case ({st_ff.awaddr[7:2], 2'b00})
        `BCC_OFS_CTRL: begin
          wr_hit = 1'b1;
          if (st_ff.wstrb[0]) begin
            nxt_st.soft_off = st_ff.wdata[`BCC_CTRL_SOFT_OFF];
          end
        end
        `BCC_OFS_OSC_DIV: begin
          wr_hit = 1'b1;
          nxt_st.osc_div = 16'(lane_merge({16'h0000, st_ff.osc_div},
                                          st_ff.wdata, st_ff.wstrb));
          // a divider of 0 would wrap to a 65536-cycle tick; 1 would tick every cycle
          if (nxt_st.osc_div < `BCC_OSC_DIV_MIN) begin
            nxt_st.osc_div = `BCC_OSC_DIV_MIN;
          end
        end
        `BCC_OFS_STATUS, `BCC_OFS_SPEED: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      nxt_st.aw_ok  = 1'b0;
      nxt_st.w_ok   = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_hit ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // axi read
    // read data is captured when the address is taken, so status is a snapshot
    status = 32'h0000_0000;
    status[`BCC_ST_FWD]          = fwd_db;
    status[`BCC_ST_SPACING_60]   = sp60_db;
    status[`BCC_ST_STOP_N]       = stop_n_db;
    status[`BCC_ST_HOLDOFF_DONE] = (st_ff.run == RUN_GO);
    status[`BCC_ST_DISABLE]      = dis;
    status[`BCC_ST_SUPPLY_LOW]   = supply_low;
    status[`BCC_ST_SPEED_LSB +: 2] = st_ff.speed;
    status[`BCC_ST_GATE_LSB +: 6]  = {st_ff.hi, st_ff.lo};
    status[`BCC_ST_SENSOR_BAD]   = st_ff.sensor_bad;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `BCC_OFS_CTRL:    rd_val = {31'h0000_0000, st_ff.soft_off};
      `BCC_OFS_OSC_DIV: rd_val = {16'h0000, st_ff.osc_div};
      `BCC_OFS_STATUS:  rd_val = status;
      `BCC_OFS_SPEED:   rd_val = {24'h00_0000, st_ff.level};
      default: begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_arvalid && !st_ff.rvalid) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = rd_val;
      nxt_st.rresp  = rd_hit ? `BCC_RESP_OKAY : `BCC_RESP_SLVERR;
    end else if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff          <= '0;
      st_ff.osc_div  <= OSC_DIV_DEFAULT;
      st_ff.soft_off <= `BCC_CTRL_RESET;
      st_ff.run      <= RUN_HOLD;
      st_ff.speed    <= SPD_DISABLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // readies are combinational so a request is taken in the cycle it is offered
  assign s_axi_awready = !st_ff.aw_ok && !st_ff.bvalid;
  assign s_axi_wready  = !st_ff.w_ok && !st_ff.bvalid;
  assign s_axi_bvalid  = st_ff.bvalid;
  assign s_axi_bresp   = st_ff.bresp;
  assign s_axi_arready = !st_ff.rvalid;
  assign s_axi_rvalid  = st_ff.rvalid;
  assign s_axi_rdata   = st_ff.rdata;
  assign s_axi_rresp   = st_ff.rresp;

  assign high_side_gate_a = st_ff.hi[2];
  assign high_side_gate_b = st_ff.hi[1];
  assign high_side_gate_c = st_ff.hi[0];
  assign low_side_gate_a  = st_ff.lo[2];
  assign low_side_gate_b  = st_ff.lo[1];
  assign low_side_gate_c  = st_ff.lo[0];

endmodule
